// ===== hdl/rpb_pkg.sv
package rpb_pkg;

  // Register offsets on the plain register port
  localparam logic [3:0] RPB_REG_CTRL = 4'h0;
  localparam logic [3:0] RPB_REG_STAT = 4'h4;
  localparam logic [3:0] RPB_REG_GEOM = 4'h8;

  // Status bit positions
  localparam int RPB_ST_RDW_BAD   = 0;
  localparam int RPB_ST_BYTE_BAD  = 1;
  localparam int RPB_ST_BEW_BAD   = 2;
  localparam int RPB_ST_RDW_HIT   = 3;
  localparam int RPB_ST_OCLK_BAD  = 4;
  localparam int RPB_STAT_W       = 5;

  // Geometry field split
  localparam int RPB_GEOM_HALF    = 16;

  // Byte sizes the byte enables may use
  localparam int RPB_BYTE_5       = 5;
  localparam int RPB_BYTE_8       = 8;
  localparam int RPB_BYTE_9       = 9;
  localparam int RPB_BYTE_10      = 10;

  typedef enum logic [1:0] {RPB_OC_LATCH, RPB_OC_FIRST, RPB_OC_SECOND} rpb_outclk_t;
  typedef enum logic [1:0] {RPB_AC_NONE, RPB_AC_FIRST, RPB_AC_SECOND} rpb_aclr_t;
  typedef enum logic [2:0] {
    RPB_RDW_UNSPEC,
    RPB_RDW_CONSTR,
    RPB_RDW_NEW,
    RPB_RDW_PRIOR,
    RPB_RDW_FRESH_PRIOR
  } rpb_rdw_t;

  // Control register image, most significant field first
  typedef struct packed {
    logic        init_b;
    logic        quad;
    logic        lut;
    rpb_rdw_t    rdw;
    logic        addr_aclr_en;
    logic        sclr_en;
    rpb_aclr_t   aclr;
    logic        be_clk1;
    logic        addr_clk1;
    logic        in_clk1;
    rpb_outclk_t outclk;
  } rpb_cfg_t;

  localparam int       RPB_CTRL_W   = $bits(rpb_cfg_t);
  localparam rpb_cfg_t RPB_CTRL_RST = rpb_cfg_t'(15'h0000);

endpackage

// ===== hdl/rpb_sync.sv
`timescale 1ns/1ps
`default_nettype none
module rpb_sync #(
  parameter int W = 4
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rstn,
  // Pins
  input  wire logic [W-1:0] async_in,
  // Synchronised
  output logic      [W-1:0] level,
  output logic      [W-1:0] rise
);
  import rpb_pkg::*;

  logic [W-1:0] meta_ff;
  logic [W-1:0] level_ff;
  logic [W-1:0] prev_ff;

  // The first stage feeds only the second stage
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
        meta_ff[i]  <= 1'b0;
        level_ff[i] <= 1'b0;
        prev_ff[i]  <= 1'b0;
      end else begin
        meta_ff[i]  <= async_in[i];
        level_ff[i] <= meta_ff[i];
        prev_ff[i]  <= level_ff[i];
      end
    end
    assign rise[i] = level_ff[i] & ~prev_ff[i];
  end

  assign level = level_ff;

endmodule
`default_nettype wire

// ===== hdl/rpb_bemerge.sv
`timescale 1ns/1ps
`default_nettype none
module rpb_bemerge #(
  parameter int DATA_W = 40,
  parameter int LANE_W = 8,
  parameter int LANES  = 5
) (
  // Words
  input  wire logic [DATA_W-1:0] old_word,
  input  wire logic [DATA_W-1:0] new_word,
  // Lane enables
  input  wire logic [LANES-1:0]  lane_en,
  // Result
  output logic      [DATA_W-1:0] merged
);
  import rpb_pkg::*;

  for (genvar i = 0; i < LANES; i++) begin : g_lane
    assign merged[i*LANE_W +: LANE_W] = lane_en[i] ? new_word[i*LANE_W +: LANE_W]
                                                   : old_word[i*LANE_W +: LANE_W];
  end

  // Bits beyond the last whole lane keep the stored value
  if (LANES * LANE_W < DATA_W) begin : g_tail
    assign merged[DATA_W-1:LANES*LANE_W] = old_word[DATA_W-1:LANES*LANE_W];
  end

endmodule
`default_nettype wire

// ===== hdl/rpb_port.sv
// Operation
// - The data output register runs from the first or second clock input, or the output is held by a latch; the latch here is a flop loaded each cycle.
// - The write data register is clocked by the selected first or second clock input.
// - The address register is clocked by the selected first or second clock input.
// - The byte enable register is clocked by the selected first or second clock input.
// - The output may be cleared asynchronously by a selected clear input, latch included, or not at all.
// - The output may be cleared synchronously by the sync clear input, latch included, or not at all.
// - The address register may be cleared by the first asynchronous clear input, or not at all.
// - The byte enable width is the data width over the byte size, and one only when byte enables are unused.
// - The byte size is one of five, eight, nine or ten bits.
// - Read during write picks among unspecified, constrained, new, prior and fresh-first-prior-second, unspecified by default.
// - New data on read during write needs lookup table mode with the write clock on read address and output.
// - The constrained unspecified choice needs lookup table mode.
// - The fresh-first-prior-second choice needs the four port configuration.
// - The initialization layout follows port A or port B, whose width and depth then apply.
//
// Local design decisions: the address map and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module rpb_port #(
  parameter int DATA_W    = 40,
  parameter int ADDR_W    = 8,
  parameter int USE_BE    = 1,
  parameter int BYTE_SIZE = 8,
  parameter int A_WIDTH   = 40,
  parameter int A_DEPTH   = 256,
  parameter int BE_W      = (USE_BE != 0) ? DATA_W / BYTE_SIZE : 1
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rstn,
  // Register port
  input  wire logic [3:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [31:0]       reg_rdata,
  // Clock and clear pins
  input  wire logic              first_clock_input,
  input  wire logic              second_clock_input,
  input  wire logic              first_async_clear_input,
  input  wire logic              second_async_clear_input,
  // User side of port B
  input  wire logic              sync_clear_input,
  input  wire logic [ADDR_W-1:0] b_addr,
  input  wire logic [DATA_W-1:0] b_wdata,
  input  wire logic              b_wren,
  input  wire logic [BE_W-1:0]   b_byteena,
  output logic      [DATA_W-1:0] b_q
);
  import rpb_pkg::*;

  localparam int DEPTH  = 1 << ADDR_W;
  localparam int LANE_W = (USE_BE != 0) ? BYTE_SIZE : DATA_W;
  localparam int LANES  = (USE_BE != 0) ? BE_W : 1;

  // Parameter sanity, reported in status
  localparam logic BYTE_BAD = (USE_BE != 0) && (BYTE_SIZE != RPB_BYTE_5) && (BYTE_SIZE != RPB_BYTE_8) &&
                              (BYTE_SIZE != RPB_BYTE_9) && (BYTE_SIZE != RPB_BYTE_10);
  localparam logic BEW_BAD  = (USE_BE != 0) ? (BE_W * BYTE_SIZE != DATA_W) || (BE_W < 2)
                                            : (BE_W != 1);

  rpb_cfg_t              cfg_ff;
  logic [31:0]           reg_rdata_ff;
  logic                  rdw_hit_ff;
  logic [ADDR_W-1:0]     addr_ff;
  logic [DATA_W-1:0]     wdata_ff;
  logic                  wren_ff;
  logic [BE_W-1:0]       be_ff;
  logic                  wr_go_ff;
  logic [DATA_W-1:0]     q_ff;
  logic [DATA_W-1:0]     mem [DEPTH];

  logic [3:0]            pin_level;
  logic [3:0]            pin_rise;
  logic                  clk0_ev;
  logic                  clk1_ev;
  logic                  clr0_lv;
  logic                  clr1_lv;
  logic                  in_ev;
  logic                  addr_ev;
  logic                  be_ev;
  logic                  out_ev;
  logic                  oclk_bad;
  logic                  out_on_in_clk;
  logic                  oaclr_act;
  logic                  rdw_bad;
  rpb_rdw_t              rdw_eff;
  logic                  collide;
  logic [LANES-1:0]      lane_en;
  logic [DATA_W-1:0]     rd_old;
  logic [DATA_W-1:0]     merged;
  logic [DATA_W-1:0]     nxt_q;
  logic [RPB_STAT_W-1:0] stat;
  logic [31:0]           geom;

  // Pins come from outside the clock domain
  rpb_sync #(
    .W (4)
  ) u_sync (
    .clk      (clk),
    .rstn     (rstn),
    .async_in ({second_async_clear_input, first_async_clear_input, second_clock_input, first_clock_input}),
    .level    (pin_level),
    .rise     (pin_rise)
  );

  assign clk0_ev = pin_rise[0];
  assign clk1_ev = pin_rise[1];
  assign clr0_lv = pin_level[2];
  assign clr1_lv = pin_level[3];

  // Each port B register follows its own selected clock input
  assign in_ev   = cfg_ff.in_clk1   ? clk1_ev : clk0_ev;
  assign addr_ev = cfg_ff.addr_clk1 ? clk1_ev : clk0_ev;
  assign be_ev   = cfg_ff.be_clk1   ? clk1_ev : clk0_ev;

  // Latch mode loads every cycle: it follows the array one clock later
  always_comb begin
    oclk_bad      = 1'b0;
    out_on_in_clk = 1'b0;
    unique case (cfg_ff.outclk)
      RPB_OC_LATCH:  out_ev = 1'b1;
      RPB_OC_FIRST: begin
        out_ev        = clk0_ev;
        out_on_in_clk = !cfg_ff.in_clk1;
      end
      RPB_OC_SECOND: begin
        out_ev        = clk1_ev;
        out_on_in_clk = cfg_ff.in_clk1;
      end
      default: begin
        out_ev   = 1'b1;
        oclk_bad = 1'b1;
      end
    endcase
  end

  // Same clear select serves register or latch alike
  always_comb begin
    unique case (cfg_ff.aclr)
      RPB_AC_NONE:   oaclr_act = 1'b0;
      RPB_AC_FIRST:  oaclr_act = clr0_lv;
      RPB_AC_SECOND: oaclr_act = clr1_lv;
      default:       oaclr_act = 1'b0;
    endcase
  end

  // Illegal read-during-write choices fall back to unspecified
  always_comb begin
    unique case (cfg_ff.rdw)
      RPB_RDW_UNSPEC:      rdw_bad = 1'b0;
      RPB_RDW_CONSTR:      rdw_bad = !cfg_ff.lut;
      RPB_RDW_NEW:         rdw_bad = !(cfg_ff.lut && out_on_in_clk &&
                                       (cfg_ff.addr_clk1 == cfg_ff.in_clk1));
      RPB_RDW_PRIOR:       rdw_bad = 1'b0;
      RPB_RDW_FRESH_PRIOR: rdw_bad = !cfg_ff.quad;
      default:             rdw_bad = 1'b1;
    endcase
  end

  assign rdw_eff = rdw_bad ? RPB_RDW_UNSPEC : cfg_ff.rdw;

  // Registers of the configuration port
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfg_ff <= RPB_CTRL_RST;
    end else if (reg_wr && reg_addr == RPB_REG_CTRL) begin
      cfg_ff <= rpb_cfg_t'(reg_wdata[RPB_CTRL_W-1:0]);
    end
  end

  // Collision flag: a new hit wins over a write-one clear
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdw_hit_ff <= 1'b0;
    end else if (collide) begin
      rdw_hit_ff <= 1'b1;
    end else if (reg_wr && reg_addr == RPB_REG_STAT && reg_wdata[RPB_ST_RDW_HIT]) begin
      rdw_hit_ff <= 1'b0;
    end
  end

  assign stat = {oclk_bad, rdw_hit_ff, BEW_BAD, BYTE_BAD, rdw_bad};
  assign geom = cfg_ff.init_b ? {RPB_GEOM_HALF'(DEPTH), RPB_GEOM_HALF'(DATA_W)}
                              : {RPB_GEOM_HALF'(A_DEPTH), RPB_GEOM_HALF'(A_WIDTH)};

  // Read data stand for one cycle only, unmapped reads give zero
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata_ff <= 32'h0000_0000;
    end else if (reg_rd) begin
      unique case (reg_addr)
        RPB_REG_CTRL: reg_rdata_ff <= 32'(cfg_ff);
        RPB_REG_STAT: reg_rdata_ff <= 32'(stat);
        RPB_REG_GEOM: reg_rdata_ff <= geom;
        default:      reg_rdata_ff <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata_ff <= 32'h0000_0000;
    end
  end

  // Address register with optional clear from the first clear input
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      addr_ff <= '0;
    end else if (cfg_ff.addr_aclr_en && clr0_lv) begin
      addr_ff <= '0;
    end else if (addr_ev) begin
      addr_ff <= b_addr;
    end
  end

  // Write enable rides with the data it qualifies
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wdata_ff <= '0;
      wren_ff  <= 1'b0;
    end else if (in_ev) begin
      wdata_ff <= b_wdata;
      wren_ff  <= b_wren;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      be_ff <= '0;
    end else if (be_ev) begin
      be_ff <= b_byteena;
    end
  end

  // Write lands the cycle after the data capture
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_go_ff <= 1'b0;
    end else begin
      wr_go_ff <= in_ev && b_wren;
    end
  end

  // Byte enables are forced on when unused
  assign lane_en = (USE_BE != 0) ? LANES'(be_ff) : '1;
  assign rd_old  = mem[addr_ff];

  rpb_bemerge #(
    .DATA_W (DATA_W),
    .LANE_W (LANE_W),
    .LANES  (LANES)
  ) u_merge (
    .old_word (rd_old),
    .new_word (wdata_ff),
    .lane_en  (lane_en),
    .merged   (merged)
  );

  // Array has no reset; contents are undefined until written
  always_ff @(posedge clk) begin
    if (wr_go_ff) begin
      mem[addr_ff] <= merged;
    end
  end

  // Port B sees prior data except where new data is legal
  assign collide = wr_go_ff && out_ev;
  assign nxt_q   = (collide && rdw_eff == RPB_RDW_NEW) ? merged : rd_old;

  // Latch option is a flop loaded each cycle, so it trails the array by one clock
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q_ff <= '0;
    end else if (oaclr_act) begin
      q_ff <= '0;
    end else if (out_ev) begin
      if (cfg_ff.sclr_en && sync_clear_input) begin
        q_ff <= '0;
      end else begin
        q_ff <= nxt_q;
      end
    end
  end

  assign b_q       = q_ff;
  assign reg_rdata = reg_rdata_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_wr_issue;
    in_ev && b_wren;
  endsequence

  sequence s_new_hit;
    collide && rdw_eff == RPB_RDW_NEW && !oaclr_act && !(cfg_ff.sclr_en && sync_clear_input);
  endsequence

  sequence s_prior_hit;
    collide && rdw_eff != RPB_RDW_NEW && !oaclr_act && !(cfg_ff.sclr_en && sync_clear_input);
  endsequence

  sequence s_latch_load;
    cfg_ff.outclk == RPB_OC_LATCH && !oaclr_act && !(cfg_ff.sclr_en && sync_clear_input);
  endsequence

  sequence s_hit_clear;
    reg_wr && reg_addr == RPB_REG_STAT && reg_wdata[RPB_ST_RDW_HIT] && !collide;
  endsequence

  AST_OUT_HOLD: assert property (cfg_ff.outclk == RPB_OC_FIRST && !clk0_ev && !oaclr_act |=> $stable(b_q))
    else $error("output register moved without its clock");
  AST_WR_CAPTURE: assert property (s_wr_issue |=> wr_go_ff && wren_ff && wdata_ff == $past(b_wdata))
    else $error("write data not captured on its clock");
  AST_ADDR_HOLD: assert property (!addr_ev && !(cfg_ff.addr_aclr_en && clr0_lv) |=> $stable(addr_ff))
    else $error("address register moved without its clock");
  AST_BE_HOLD: assert property (!be_ev |=> $stable(be_ff))
    else $error("byte enable register moved without its clock");
  AST_OUT_ACLR: assert property (oaclr_act |=> b_q == '0)
    else $error("output not cleared by asynchronous clear");
  AST_OUT_SCLR: assert property (out_ev && cfg_ff.sclr_en && sync_clear_input |=> b_q == '0)
    else $error("output not cleared by synchronous clear");
  AST_ADDR_ACLR: assert property (cfg_ff.addr_aclr_en && clr0_lv |=> addr_ff == '0)
    else $error("address register not cleared");
  AST_RDW_NEW: assert property (s_new_hit |=> b_q == $past(merged))
    else $error("new data not returned on read during write");
  AST_RDW_CONSTR: assert property (cfg_ff.rdw == RPB_RDW_CONSTR && !cfg_ff.lut |-> rdw_eff == RPB_RDW_UNSPEC)
    else $error("constrained choice accepted outside lookup table mode");
  AST_RDW_QUAD: assert property (cfg_ff.rdw == RPB_RDW_FRESH_PRIOR && !cfg_ff.quad |-> rdw_bad)
    else $error("fresh-prior choice accepted without four ports");

  // Address and byte enable registers load at their own clock event; write data and output registers hold without theirs
  AST_ADDR_CAPTURE: assert property (addr_ev && !(cfg_ff.addr_aclr_en && clr0_lv) |=> addr_ff == $past(b_addr))
    else $error("address not captured on its clock");
  AST_BE_CAPTURE: assert property (be_ev |=> be_ff == $past(b_byteena))
    else $error("byte enables not captured on their clock");
  AST_IN_HOLD: assert property (!in_ev |=> $stable(wdata_ff) && $stable(wren_ff))
    else $error("write data register moved without its clock");
  AST_OUT_HOLD2: assert property (cfg_ff.outclk == RPB_OC_SECOND && !clk1_ev && !oaclr_act |=> $stable(b_q))
    else $error("output register moved without the second clock");

  // Latch option and ordinary collisions both hand over the stored word
  AST_LATCH_FOLLOW: assert property (s_latch_load |=> b_q == $past(rd_old))
    else $error("latched output does not follow the array");
  AST_RDW_PRIOR: assert property (s_prior_hit |=> b_q == $past(rd_old))
    else $error("prior data not returned on read during write");
  AST_HIT_SET: assert property (collide |=> rdw_hit_ff)
    else $error("collision flag not set");
  AST_HIT_CLEAR: assert property (s_hit_clear |=> !rdw_hit_ff)
    else $error("collision flag not cleared");

endmodule
`default_nettype wire

// ===== bench/rpb_user.sv
`timescale 1ns/1ps
`default_nettype none
module rpb_user (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rstn,
  // Command
  input  wire logic req,
  input  wire logic sel,
  // Clock pins, still outside frames
  output logic      pin0,
  output logic      pin1,
  output logic      done
);
  int   cnt;
  logic s_ff;

  // Pulse high 3 and low 4 cycles so the synchronisers see both levels
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt  <= 0;
      s_ff <= 1'b0;
      pin0 <= 1'b0;
      pin1 <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= (cnt == 6);
      if (cnt == 0 && req) begin
        cnt  <= 1;
        s_ff <= sel;
      end else if (cnt != 0) begin
        cnt <= (cnt == 6) ? 0 : cnt + 1;
      end
      pin0 <= (cnt == 0) ? (req && !sel) : (cnt < 3) && !s_ff;
      pin1 <= (cnt == 0) ? (req && sel) : (cnt < 3) && s_ff;
    end
  end
endmodule
`default_nettype wire

// ===== bench/rpb_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
module rpb_port_tb;
  import rpb_pkg::*;
  logic        clk, rstn, reg_wr, reg_rd, aclr0, aclr1, sclr, b_wren, req, done, p0, p1, ok;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rv;
  logic [7:0]  b_addr, a;
  logic [39:0] b_wdata, b_q;
  logic [4:0]  b_byteena;
  logic [39:0] mem [int];
  rpb_cfg_t    cfg;
  int          n_errors, compares, seed;

  rpb_port #(.A_WIDTH(32), .A_DEPTH(128)) uut (
    .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .first_clock_input(p0), .second_clock_input(p1),
    .first_async_clear_input(aclr0), .second_async_clear_input(aclr1), .sync_clear_input(sclr),
    .b_addr(b_addr), .b_wdata(b_wdata), .b_wren(b_wren), .b_byteena(b_byteena), .b_q(b_q));
  rpb_user u_user (.clk(clk), .rstn(rstn), .req(req), .sel(cfg.in_clk1), .pin0(p0), .pin1(p1),
    .done(done));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task test_done;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task chk_reg(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %0t reg %h exp %h", $time, g, e);
    end
  endtask

  task chk_q(input logic [39:0] g, input logic [39:0] e);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %0t q %h exp %h", $time, g, e);
    end
  endtask

  task wr(input logic [3:0] ad, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= ad;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task rd(input logic [3:0] ad, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= ad;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task setc;
    wr(RPB_REG_CTRL, {17'h0, cfg});
  endtask

  // One frame on the selected clock pin; the model follows lane enables
  task ev(input logic [7:0] ad, input logic w, input logic [4:0] be);
    logic [39:0] d;
    int          k;
    d = {8'($random(seed)), $random(seed)};
    @(posedge clk);
    b_addr    <= ad;
    b_wdata   <= d;
    b_wren    <= w;
    b_byteena <= be;
    req       <= 1'b1;
    @(posedge clk);
    req <= 1'b0;
    k = 0;
    while (done !== 1'b1 && k < 20) begin
      @(posedge clk);
      #1 k++;
    end
    if (k == 20) begin
      n_errors++;
      test_done;
    end
    b_wdata <= ~d;
    if (w) begin
      if (!mem.exists(ad))
        mem[ad] = 40'h0;
      for (int i = 0; i < 5; i++)
        if (be[i])
          mem[ad][i*8+:8] = d[i*8+:8];
    end
  endtask

  task rdq(input logic [7:0] ad);
    ev(ad, 1'b0, 5'h00);
    ev(ad, 1'b0, 5'h00);
    repeat (2) @(posedge clk);
    #1 chk_q(b_q, mem[ad]);
  endtask

  initial begin
    repeat (50000) @(posedge clk);
    n_errors++;
    test_done;
  end

  initial begin
    seed = 19;
    {rstn, reg_wr, reg_rd, aclr0, aclr1, sclr, b_wren, req} = 8'h00;
    {reg_addr, reg_wdata, b_addr, b_wdata, b_byteena} = '0;
    cfg = RPB_CTRL_RST;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    rd(RPB_REG_CTRL, rv);
    chk_reg(rv, 32'h0);
    rd(RPB_REG_STAT, rv);
    chk_reg(rv, 32'h0);
    rd(4'hc, rv);
    chk_reg(rv, 32'h0);
    rd(RPB_REG_GEOM, rv);
    chk_reg(rv, {16'h0080, 16'h0020});
    cfg.init_b = 1'b1;
    setc;
    wr(4'hc, 32'hffff);
    rd(RPB_REG_CTRL, rv);
    chk_reg(rv, {17'h0, cfg});
    rd(RPB_REG_GEOM, rv);
    chk_reg(rv, {16'h0100, 16'h0028});
    for (int i = 0; i < 40; i++) begin
      cfg.rdw       = rpb_rdw_t'(i % 5);
      cfg.lut       = 1'($random(seed));
      cfg.quad      = 1'($random(seed));
      cfg.addr_clk1 = 1'($random(seed));
      cfg.in_clk1   = 1'($random(seed));
      cfg.outclk    = rpb_outclk_t'(2'($random(seed)));
      ok = (i % 5 == 1) ? cfg.lut : (i % 5 == 4) ? cfg.quad : (i % 5 != 2) ||
           (cfg.lut && cfg.addr_clk1 == cfg.in_clk1 && cfg.outclk == (cfg.addr_clk1 ? RPB_OC_SECOND : RPB_OC_FIRST));
      setc;
      rd(RPB_REG_STAT, rv);
      chk_reg(rv, {27'h0, cfg.outclk == 2'h3, 3'h0, !ok});
    end
    cfg = RPB_CTRL_RST;
    for (int m = 0; m < 3; m++) begin
      cfg.outclk = rpb_outclk_t'(m);
      {cfg.in_clk1, cfg.addr_clk1, cfg.be_clk1} = {3{m == 2}};
      setc;
      a = 8'($random(seed));
      ev(a, 1'b1, 5'h1f);
      ev(a, 1'b1, 5'($random(seed)));
      rdq(a);
    end
    cfg.outclk = RPB_OC_FIRST;
    {cfg.in_clk1, cfg.addr_clk1, cfg.be_clk1} = 3'h0;
    for (int c = 1; c < 3; c++) begin
      cfg.aclr = rpb_aclr_t'(c);
      setc;
      rdq(a);
      aclr0 <= (c == 1);
      aclr1 <= (c == 2);
      repeat (5) @(posedge clk);
      #1 chk_q(b_q, 40'h0);
      aclr0 <= 1'b0;
      aclr1 <= 1'b0;
    end
    cfg.aclr    = RPB_AC_NONE;
    cfg.sclr_en = 1'b1;
    setc;
    rdq(a);
    sclr <= 1'b1;
    ev(a, 1'b0, 5'h00);
    #1 chk_q(b_q, 40'h0);
    sclr <= 1'b0;
    rdq(a);
    // Latch mode shows the word at the address register one clock later
    cfg              = RPB_CTRL_RST;
    cfg.addr_aclr_en = 1'b1;
    setc;
    ev(8'h00, 1'b1, 5'h1f);
    ev(8'h5a, 1'b1, 5'h1f);
    repeat (3) @(posedge clk);
    #1 chk_q(b_q, mem[8'h5a]);
    aclr0 <= 1'b1;
    repeat (6) @(posedge clk);
    #1 chk_q(b_q, mem[8'h00]);
    aclr0 <= 1'b0;
    // Latch writes collided with the always-open output
    rd(RPB_REG_STAT, rv);
    chk_reg(rv, 32'h1 << RPB_ST_RDW_HIT);
    wr(RPB_REG_STAT, 32'h1 << RPB_ST_RDW_HIT);
    rd(RPB_REG_STAT, rv);
    chk_reg(rv, 32'h0);
    test_done;
  end
endmodule
`default_nettype wire
